//--- rtl/ldc_pkg.sv
`default_nettype none

package ldc_pkg;

  // register addresses, upper nibble of the data bus
  localparam logic [3:0] ADDR_X_LOW      = 4'h0;
  localparam logic [3:0] ADDR_X_HIGH     = 4'h1;
  localparam logic [3:0] ADDR_Y_LOW      = 4'h2;
  localparam logic [3:0] ADDR_Y_HIGH     = 4'h3;
  localparam logic [3:0] ADDR_START_LOW  = 4'h4;
  localparam logic [3:0] ADDR_START_HIGH = 4'h5;
  localparam logic [3:0] ADDR_ALT_LOW    = 4'h6;
  localparam logic [3:0] ADDR_ALT_HIGH   = 4'h7;
  localparam logic [3:0] ADDR_DISP_ONE   = 4'h8;
  localparam logic [3:0] ADDR_DISP_TWO   = 4'h9;
  localparam logic [3:0] ADDR_STEP       = 4'hA;
  localparam logic [3:0] ADDR_POWER      = 4'hB;
  localparam logic [3:0] ADDR_DUTY       = 4'hC;
  localparam logic [3:0] ADDR_READ_PTR   = 4'hC;
  localparam logic [3:0] ADDR_BANK       = 4'hF;

  // bank numbers
  localparam logic [2:0] BANK_MAIN = 3'h0;
  localparam logic [2:0] BANK_PTR  = 3'h2;

  // field positions
  localparam int DISP_ENABLE  = 0;
  localparam int DISP_ALL_LIT = 1;
  localparam int DISP_BILEVEL = 2;
  localparam int DISP_SCAN_UP = 3;
  localparam int CTL_MIRROR   = 0;
  localparam int CTL_ALT_EN   = 2;
  localparam int CTL_INVERT   = 3;
  localparam int STEP_X       = 0;
  localparam int STEP_Y       = 1;
  localparam int STEP_WR_ONLY = 2;
  localparam int PWR_INIT     = 0;
  localparam int PWR_PUMP     = 1;
  localparam int PWR_SAVE     = 2;
  localparam int PWR_REG      = 3;

  // values after reset and counts
  localparam logic [3:0] REG_RESET    = 4'h0;
  localparam logic [3:0] UPPER_READ   = 4'hF;
  localparam logic [7:0] LINE_COUNT   = 8'h43;
  localparam logic [6:0] LAST_LINE    = 7'(LINE_COUNT - 8'h01);
  localparam logic [6:0] Y_LAST       = 7'h44;
  localparam logic [4:0] X_LIMIT_MONO = 5'h19;
  localparam logic [1:0] INIT_TICKS   = 2'h2;
  localparam logic [12:0] PINS_IDLE   = 13'h1600;

  // synchronised parallel bus and timebase pins
  typedef struct packed {
    logic       cs_n;
    logic       register_select;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       tick;
    logic [7:0] data;
  } ldc_pins_t;

  typedef struct packed {
    logic [4:0] x_addr;
    logic [6:0] y_addr;
  } ldc_ram_addr_t;

  typedef struct packed {
    logic [6:0] start_line_addr;
    logic [6:0] common_row;
    logic       alternation;
    logic       display_reset;
    logic [1:0] pixel_level;
    logic       drivers_grounded;
  } ldc_display_t;

  typedef struct packed {
    logic pump_enable;
    logic regulator_enable;
    logic osc_run;
  } ldc_power_t;

  // rows shown for each duty code
  function automatic logic [6:0] duty_rows(input logic [2:0] code);
    unique case (code)
      3'h0: duty_rows = LAST_LINE + 7'h01;
      3'h1: duty_rows = 7'h38;
      3'h2: duty_rows = 7'h30;
      3'h3: duty_rows = 7'h28;
      3'h4: duty_rows = 7'h20;
      3'h5: duty_rows = 7'h18;
      3'h6: duty_rows = 7'h10;
      3'h7: duty_rows = 7'h08;
    endcase
  endfunction

endpackage

`default_nettype wire

//--- rtl/ldc_sync.sv
`default_nettype none

module ldc_sync #(
  parameter int          WIDTH      = 13,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // pins and their settled copy
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] settled;
  } ldc_sync_state_t;

  ldc_sync_state_t st;
  ldc_sync_state_t next_st;

  // a bit changes only once second and third stage agree
  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.settled[i] = st.s3[i];
      end
    end
  end

  // idle pin levels at reset so no false strobe edge appears
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st.s1      <= RESET_VALUE;
      st.s2      <= RESET_VALUE;
      st.s3      <= RESET_VALUE;
      st.settled <= RESET_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.settled;

endmodule // ldc_sync

`default_nettype wire

//--- rtl/ldc_bank.sv
`default_nettype none

module ldc_bank #(
  parameter logic [4:0] X_LIMIT_GRAY = 5'h19
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // parallel microprocessor pins
  input  wire logic                   cs_n,
  input  wire logic                   register_select,
  input  wire logic                   write_strobe_n,
  input  wire logic                   read_strobe_n,
  input  wire logic [7:0]             data_in,
  output logic      [7:0]             data_out,
  output logic                        data_oe,
  // display memory side
  input  wire logic [7:0]             ram_rdata,
  input  wire logic [1:0]             pixel_data,
  output ldc_pkg::ldc_ram_addr_t      ram_addr,
  // external display timebase
  input  wire logic                   ext_timebase_in,
  // drive and power controls
  output ldc_pkg::ldc_display_t       display,
  output ldc_pkg::ldc_power_t         power
);

  typedef struct packed {
    logic [15:0][3:0]        regs;
    logic [4:0]              x_counter;
    logic [6:0]              y_counter;
    logic [3:0]              bank_select;
    logic [3:0]              read_pointer;
    logic                    wr_prev;
    logic                    rd_prev;
    logic                    tick_prev;
    logic [7:0]              data_out;
    logic                    data_oe;
    logic [1:0]              init_count;
    logic [6:0]              row;
    logic [6:0]              alt_count;
    ldc_pkg::ldc_ram_addr_t  ram_addr;
    ldc_pkg::ldc_display_t   display;
    ldc_pkg::ldc_power_t     power;
  } ldc_bank_state_t;

  ldc_bank_state_t   st;
  ldc_bank_state_t   next_st;
  ldc_pkg::ldc_pins_t pins;

  // all pin inputs share one settling stage so data and strobes stay aligned
  ldc_sync #(
    .WIDTH       (13),
    .RESET_VALUE (ldc_pkg::PINS_IDLE)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({cs_n, register_select, write_strobe_n, read_strobe_n,
                ext_timebase_in, data_in}),
    .sync_out (pins)
  );

  // writable bits of each main bank register; others are ignored
  function automatic logic [3:0] write_mask(input logic [3:0] addr);
    unique case (addr)
      ldc_pkg::ADDR_START_HIGH,
      ldc_pkg::ADDR_ALT_HIGH,
      ldc_pkg::ADDR_STEP,
      ldc_pkg::ADDR_DUTY:      write_mask = 4'h7;
      ldc_pkg::ADDR_DISP_TWO:  write_mask = 4'hD;
      ldc_pkg::ADDR_START_LOW,
      ldc_pkg::ADDR_ALT_LOW,
      ldc_pkg::ADDR_DISP_ONE,
      ldc_pkg::ADDR_POWER:     write_mask = 4'hF;
      default:                 write_mask = 4'h0;
    endcase
  endfunction

  // nibble seen by a register read at the pointer
  function automatic logic [3:0] read_nibble(input ldc_bank_state_t s);
    logic [3:0] addr;
    addr = s.read_pointer;
    read_nibble = ldc_pkg::REG_RESET;
    if (addr == ldc_pkg::ADDR_BANK) begin
      read_nibble = s.bank_select;
    end else if (s.bank_select[2:0] == ldc_pkg::BANK_PTR) begin
      if (addr == ldc_pkg::ADDR_READ_PTR) begin
        read_nibble = s.read_pointer;
      end
    end else if (s.bank_select[2:0] == ldc_pkg::BANK_MAIN) begin
      unique case (addr)
        ldc_pkg::ADDR_X_LOW:  read_nibble = s.x_counter[3:0];
        ldc_pkg::ADDR_X_HIGH: read_nibble = {3'h0, s.x_counter[4]};
        ldc_pkg::ADDR_Y_LOW:  read_nibble = s.y_counter[3:0];
        ldc_pkg::ADDR_Y_HIGH: read_nibble = {1'h0, s.y_counter[6:4]};
        default:              read_nibble = s.regs[addr];
      endcase
    end
  endfunction

  always_comb begin
    logic       wr_rise;
    logic       rd_rise;
    logic       reg_wr;
    logic       ram_access;
    logic       tick_rise;
    logic       save;
    logic       bilevel;
    logic       frame_end;
    logic [3:0] addr;
    logic [3:0] val;
    logic [4:0] x_limit;
    logic [6:0] rows;
    logic [6:0] alt_code;
    logic [7:0] line_sum;
    logic [1:0] level;
    wr_rise    = 1'b0;
    rd_rise    = 1'b0;
    reg_wr     = 1'b0;
    ram_access = 1'b0;
    tick_rise  = 1'b0;
    save       = 1'b0;
    bilevel    = 1'b0;
    frame_end  = 1'b0;
    addr       = 4'h0;
    val        = 4'h0;
    x_limit    = 5'h00;
    rows       = 7'h00;
    alt_code   = 7'h00;
    line_sum   = 8'h00;
    level      = 2'h0;
    next_st    = st;

    // strobe edges from the settled pins
    wr_rise = pins.write_strobe_n & ~st.wr_prev & ~pins.cs_n;
    rd_rise = pins.read_strobe_n & ~st.rd_prev & ~pins.cs_n;
    next_st.wr_prev   = pins.write_strobe_n;
    next_st.rd_prev   = pins.read_strobe_n;
    next_st.tick_prev = pins.tick;
    addr   = pins.data[7:4];
    val    = pins.data[3:0];
    reg_wr = wr_rise & pins.register_select;

    save      = st.regs[ldc_pkg::ADDR_POWER][ldc_pkg::PWR_SAVE];
    bilevel   = st.regs[ldc_pkg::ADDR_DISP_ONE][ldc_pkg::DISP_BILEVEL];
    x_limit   = bilevel ? ldc_pkg::X_LIMIT_MONO : X_LIMIT_GRAY;
    rows      = ldc_pkg::duty_rows(st.regs[ldc_pkg::ADDR_DUTY][2:0]);
    alt_code  = {st.regs[ldc_pkg::ADDR_ALT_HIGH][2:0], st.regs[ldc_pkg::ADDR_ALT_LOW]};
    // the timebase is ignored entirely while saving power
    tick_rise = pins.tick & ~st.tick_prev & ~save;

    // address stepping on display memory access
    ram_access = ~pins.register_select & (wr_rise |
                 (rd_rise & ~st.regs[ldc_pkg::ADDR_STEP][ldc_pkg::STEP_WR_ONLY]));
    if (ram_access) begin
      unique case (st.regs[ldc_pkg::ADDR_STEP][1:0])
        2'h0: begin
        end
        2'h1: begin
          next_st.x_counter = (st.x_counter >= x_limit) ? 5'h00 : st.x_counter + 5'h01;
        end
        2'h2: begin
          next_st.y_counter = (st.y_counter >= ldc_pkg::Y_LAST) ? 7'h00 :
                              st.y_counter + 7'h01;
        end
        2'h3: begin
          if (st.x_counter >= x_limit) begin
            next_st.x_counter = 5'h00;
            next_st.y_counter = (st.y_counter >= ldc_pkg::Y_LAST) ? 7'h00 :
                                st.y_counter + 7'h01;
          end else begin
            next_st.x_counter = st.x_counter + 5'h01;
          end
        end
      endcase
    end

    // row scan and soft init, one step per timebase edge
    if (tick_rise) begin
      if (st.display.display_reset) begin
        next_st.row                 = 7'h00;
        next_st.alt_count           = 7'h00;
        next_st.display.alternation = 1'b0;
        if (st.init_count == 2'h1) begin
          next_st.display.display_reset = 1'b0;
        end
        next_st.init_count = st.init_count - 2'h1;
      end else if (st.regs[ldc_pkg::ADDR_POWER][ldc_pkg::PWR_INIT]) begin
        next_st.display.display_reset = 1'b1;
        next_st.init_count = ldc_pkg::INIT_TICKS;
        // scan restarts as the reset begins, not one step later
        next_st.row                 = 7'h00;
        next_st.alt_count           = 7'h00;
        next_st.display.alternation = 1'b0;
        next_st.regs[ldc_pkg::ADDR_POWER][ldc_pkg::PWR_INIT] = 1'b0;
      end else begin
        frame_end   = (st.row >= rows - 7'h01);
        next_st.row = frame_end ? 7'h00 : st.row + 7'h01;
        if (st.regs[ldc_pkg::ADDR_DISP_TWO][ldc_pkg::CTL_ALT_EN]) begin
          // code k means k+1 lines between reversals
          if (st.alt_count >= alt_code) begin
            next_st.alt_count           = 7'h00;
            next_st.display.alternation = ~st.display.alternation;
          end else begin
            next_st.alt_count = st.alt_count + 7'h01;
          end
        end else if (frame_end) begin
          next_st.alt_count           = 7'h00;
          next_st.display.alternation = ~st.display.alternation;
        end
      end
    end

    // register writes come last so a host set beats the self-clear
    if (reg_wr) begin
      if (addr == ldc_pkg::ADDR_BANK) begin
        next_st.bank_select = val;
      end else if (st.bank_select[2:0] == ldc_pkg::BANK_PTR) begin
        if (addr == ldc_pkg::ADDR_READ_PTR) begin
          next_st.read_pointer = val;
        end
      end else if (st.bank_select[2:0] == ldc_pkg::BANK_MAIN) begin
        unique case (addr)
          ldc_pkg::ADDR_X_LOW:  next_st.x_counter[3:0] = val;
          ldc_pkg::ADDR_X_HIGH: next_st.x_counter[4]   = val[0];
          ldc_pkg::ADDR_Y_LOW:  next_st.y_counter[3:0] = val;
          ldc_pkg::ADDR_Y_HIGH: next_st.y_counter[6:4] = val[2:0];
          default: begin
            // stepping enables change, counters kept as they are
            next_st.regs[addr] = (st.regs[addr] & ~write_mask(addr)) |
                                 (val & write_mask(addr));
          end
        endcase
      end
    end

    // data bus: register read shows high upper nibble
    next_st.data_oe  = ~pins.cs_n & ~pins.read_strobe_n;
    next_st.data_out = 8'h00;
    if (next_st.data_oe) begin
      next_st.data_out = pins.register_select ? {ldc_pkg::UPPER_READ, read_nibble(st)} :
                         ram_rdata;
    end

    // internal X address, mirrored against the mode limit
    next_st.ram_addr.y_addr = next_st.y_counter;
    next_st.ram_addr.x_addr = st.regs[ldc_pkg::ADDR_DISP_TWO][ldc_pkg::CTL_MIRROR] ?
                              x_limit - next_st.x_counter :
                              next_st.x_counter;

    // line address wraps past the last line
    line_sum = {1'b0, st.regs[ldc_pkg::ADDR_START_HIGH][2:0],
                st.regs[ldc_pkg::ADDR_START_LOW]} + {1'b0, next_st.row};
    if (line_sum > {1'b0, ldc_pkg::LAST_LINE}) begin
      line_sum = line_sum - ldc_pkg::LINE_COUNT;
    end
    next_st.display.start_line_addr = line_sum[6:0];
    next_st.display.common_row =
      st.regs[ldc_pkg::ADDR_DISP_ONE][ldc_pkg::DISP_SCAN_UP] ?
      ldc_pkg::LAST_LINE - next_st.row : next_st.row;

    // pixel drive level: saving, off, all lit, then data with inversion
    level = bilevel ? {2{pixel_data[0]}} : pixel_data;
    if (st.regs[ldc_pkg::ADDR_DISP_TWO][ldc_pkg::CTL_INVERT]) begin
      level = ~level;
    end
    if (st.regs[ldc_pkg::ADDR_DISP_ONE][ldc_pkg::DISP_ALL_LIT]) begin
      level = 2'h3;
    end
    if (save || !st.regs[ldc_pkg::ADDR_DISP_ONE][ldc_pkg::DISP_ENABLE]) begin
      level = 2'h0;
    end
    next_st.display.pixel_level      = level;
    next_st.display.drivers_grounded = save;

    // supply controls; saving stops oscillator and supplies, settings kept
    next_st.power.pump_enable      = st.regs[ldc_pkg::ADDR_POWER][ldc_pkg::PWR_PUMP] & ~save;
    next_st.power.regulator_enable = st.regs[ldc_pkg::ADDR_POWER][ldc_pkg::PWR_REG] & ~save;
    next_st.power.osc_run          = ~save;
  end

  // strobe history starts high so reset release makes no edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st               <= '0;
      st.wr_prev       <= 1'b1;
      st.rd_prev       <= 1'b1;
      st.power.osc_run <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.data_out;
  assign data_oe  = st.data_oe;
  assign ram_addr = st.ram_addr;
  assign display  = st.display;
  assign power    = st.power;

endmodule // ldc_bank

`default_nettype wire

//--- dv/ldc_bank_monitor.sv
`default_nettype none

module ldc_bank_monitor #(
  parameter logic [4:0] X_LIMIT_GRAY = 5'h19
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  resetn,
  // parallel microprocessor pins
  input wire logic                  cs_n,
  input wire logic                  register_select,
  input wire logic                  write_strobe_n,
  input wire logic                  read_strobe_n,
  input wire logic [7:0]            data_in,
  input wire logic [7:0]            data_out,
  input wire logic                  data_oe,
  // display memory side
  input wire logic [7:0]            ram_rdata,
  input wire logic [1:0]            pixel_data,
  input wire ldc_pkg::ldc_ram_addr_t ram_addr,
  // timebase and drive controls
  input wire logic                  ext_timebase_in,
  input wire ldc_pkg::ldc_display_t display,
  input wire ldc_pkg::ldc_power_t   power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // init pulse and a power-save stretch, as sequences
  sequence s_init_start;
    $rose(display.display_reset);
  endsequence
  sequence s_save_on;
    display.drivers_grounded ##1 display.drivers_grounded;
  endsequence

  // bus driving follows the read strobe through the sync chain
  chk_oe_cause: assert property ($rose(data_oe) |-> $past(read_strobe_n, 3) == 1'b0 && $past(cs_n, 3) == 1'b0)
    else $error("data bus driven without a read");
  chk_oe_release: assert property ($rose(read_strobe_n) |-> ##[4:7] !data_oe)
    else $error("data bus not released after read");
  chk_upper_high: assert property (data_oe && register_select && $past(register_select, 8) |-> data_out[7:4] == ldc_pkg::UPPER_READ)
    else $error("upper read nibble not high");
  chk_idle_zero: assert property (!data_oe |-> data_out == 8'h00)
    else $error("data out not quiet while idle");
  // power save grounds drivers and freezes scanning
  chk_save_ground: assert property (display.drivers_grounded |-> !power.pump_enable && !power.regulator_enable && !power.osc_run)
    else $error("supplies running in power save");
  chk_save_freeze: assert property (s_save_on |-> $stable(display.common_row) && $stable(display.alternation))
    else $error("scan moved in power save");
  // rows and lines stay within the panel
  chk_row_range: assert property (display.common_row <= ldc_pkg::LAST_LINE)
    else $error("common row out of range");
  chk_line_range: assert property (display.start_line_addr <= ldc_pkg::LAST_LINE)
    else $error("line address out of range");
  // soft init holds alternation low; its reset lasts at least eight clocks
  chk_init_alt: assert property (display.display_reset |-> !display.alternation)
    else $error("alternation active during init");
  chk_init_hold: assert property (s_init_start |-> display.display_reset [*8])
    else $error("init reset too short");
endmodule // ldc_bank_monitor

bind ldc_bank ldc_bank_monitor #(.X_LIMIT_GRAY(X_LIMIT_GRAY)) u_monitor (
  .clk(clk), .resetn(resetn), .cs_n(cs_n), .register_select(register_select),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe), .ram_rdata(ram_rdata), .pixel_data(pixel_data),
  .ram_addr(ram_addr), .ext_timebase_in(ext_timebase_in), .display(display), .power(power));

`default_nettype wire

//--- dv/ldc_host_model.sv
`default_nettype none

module ldc_host_model (
  // clock
  input  wire logic      clk,
  // parallel bus pins
  output var logic       cs_n,
  output var logic       register_select,
  output var logic       write_strobe_n,
  output var logic       read_strobe_n,
  output var logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pins from time zero
  initial begin
    {cs_n, register_select, write_strobe_n, read_strobe_n} = 4'hF;
    data_in = 8'h00;
  end

  // one write; data held well around the strobe rise
  task automatic put(input logic rs, input logic [7:0] d);
    @(negedge clk);
    {cs_n, register_select, data_in, write_strobe_n} = {1'b0, rs, d, 1'b0};
    repeat (5) @(negedge clk);
    write_strobe_n = 1'b1;
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    data_in = ~d; // released bus must not show stale data
    repeat (4) @(negedge clk);
  endtask

  // one read; strobe long enough for the sync chain
  task automatic get(input logic rs);
    @(negedge clk);
    {cs_n, register_select, read_strobe_n} = {1'b0, rs, 1'b0};
    repeat (8) @(negedge clk);
    read_strobe_n = 1'b1;
    repeat (7) @(negedge clk);
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // pointer in bank 2, back to bank 0, then read
  task automatic reg_read(input logic [3:0] a);
    put(1'b1, {ldc_pkg::ADDR_BANK, 1'b0, ldc_pkg::BANK_PTR});
    put(1'b1, {ldc_pkg::ADDR_READ_PTR, a});
    put(1'b1, {ldc_pkg::ADDR_BANK, 1'b0, ldc_pkg::BANK_MAIN});
    get(1'b1);
  endtask
endmodule // ldc_host_model

`default_nettype wire

//--- dv/ldc_bank_tb.sv
`default_nettype none

module ldc_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0, resetn = 1'b0, ext_timebase_in = 1'b0, oe_seen = 1'b0;
  logic cs_n, register_select, write_strobe_n, read_strobe_n, data_oe;
  logic [7:0] data_in, data_out, ram_rdata = 8'h00;
  logic [1:0] pixel_data = 2'h0;
  ldc_pkg::ldc_ram_addr_t ram_addr;
  ldc_pkg::ldc_display_t  display;
  ldc_pkg::ldc_power_t    power;
  int failures = 0, total_checks = 0, cycles = 0, seed = 32'hA1AC;
  logic [15:0] exp_q[$];
  logic [7:0] rows_tab [8] = '{8'h43, 8'h38, 8'h30, 8'h28, 8'h20, 8'h18, 8'h10, 8'h08};
  logic [3:0] ra [4] = '{4'h8, 4'h9, 4'hA, 4'hC};
  logic [3:0] rm [4] = '{4'hF, 4'hD, 4'h7, 4'h7};

  ldc_bank u_dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .register_select(register_select),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ram_rdata(ram_rdata), .pixel_data(pixel_data),
    .ram_addr(ram_addr), .ext_timebase_in(ext_timebase_in), .display(display), .power(power));
  ldc_host_model u_host (.clk(clk), .cs_n(cs_n), .register_select(register_select),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .data_in(data_in));

  // 25 MHz clock
  always #20 clk = ~clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // each new read answer is matched against the oldest note
  always @(negedge clk) begin
    if (data_oe === 1'b1 && !oe_seen) begin
      check("read data", 16'(data_out), exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
    end
    oe_seen <= (data_oe === 1'b1);
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 32'h9C40) begin
      failures++;
      finish_test();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [3:0] v);
    u_host.put(1'b1, {a, v});
  endtask
  task automatic rd(input logic [3:0] a, input logic [3:0] v);
    exp_q.push_back({8'h00, ldc_pkg::UPPER_READ, v});
    u_host.reg_read(a);
  endtask
  task automatic tick;
    @(negedge clk) ext_timebase_in = 1'b1;
    repeat (5) @(negedge clk);
    ext_timebase_in = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  initial begin
    logic [6:0] s, row, top;
    logic [3:0] v;
    logic [1:0] pd;
    logic a0;
    int flips;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    // reset values, DH has nothing behind it
    for (int a = 4; a <= 13; a++) rd(4'(a), 4'h0);
    // random settings read back, don't-care bits dropped
    for (int i = 0; i < 8; i++) begin
      v = 4'($random(seed));
      wr(ra[i % 4], v);
      rd(ra[i % 4], v & rm[i % 4]);
    end
    s = 7'($unsigned($random(seed)) % 67);
    wr(4'h4, s[3:0]);
    wr(4'h5, {1'b0, s[6:4]});
    wr(4'h6, 4'h2); // three-line alternation, inside the legal range
    wr(4'h7, 4'h0);
    rd(4'h5, {1'b0, s[6:4]});
    rd(4'h6, 4'h2);
    wr(4'h9, 4'h0);
    // every duty code, scan direction alternating, restarted by soft init
    for (int d = 0; d < 8; d++) begin
      wr(4'hC, 4'(d));
      wr(4'h8, {d[0], 3'h1});
      wr(4'hB, 4'h1); // only ticks follow until init is over
      top = 7'h00;
      repeat (rows_tab[d] + 5) begin
        tick();
        row = d[0] ? 7'h42 - display.common_row : display.common_row;
        if (row > top) top = row;
        check("line", 16'(display.start_line_addr), (16'(s) + 16'(row)) % 16'h0043);
      end
      check("rows", 16'(top), 16'(rows_tab[d] - 8'h01));
    end
    // alternation per frame of eight rows, then every three lines
    for (int m = 0; m < 2; m++) begin
      wr(4'h9, {1'b0, m[0], 2'h0});
      repeat (3) tick();
      flips = 0;
      a0 = display.alternation;
      repeat (24) begin
        tick();
        if (display.alternation !== a0) flips++;
        a0 = display.alternation;
      end
      check("flips", 16'(flips), m ? 16'h0008 : 16'h0003);
    end
    // soft init starts on a timebase step and clears its bit
    wr(4'hB, 4'h1);
    tick();
    check("init", 16'(display.display_reset), 16'h0001);
    repeat (3) tick();
    check("init end", 16'(display.display_reset), 16'h0000);
    rd(4'hB, 4'h0);
    // supplies on, then power save keeps settings
    wr(4'hB, 4'hA);
    check("supplies", 16'(power), 16'h0007);
    wr(4'hB, 4'hE);
    check("save", 16'({power, display.drivers_grounded}), 16'h0001);
    tick();
    rd(4'hB, 4'hE);
    wr(4'hB, 4'h0);
    // pixel level: plain, inverted, all-lit over inverted, bilevel
    for (int c = 0; c < 4; c++) begin
      wr(4'h8, c == 2 ? 4'h3 : c == 3 ? 4'h5 : 4'h1);
      wr(4'h9, (c == 1 || c == 2) ? 4'h8 : 4'h0);
      repeat (4) begin
        pd = 2'($random(seed));
        @(negedge clk) pixel_data = pd;
        repeat (2) @(negedge clk);
        check("pixel", 16'(display.pixel_level),
              16'(c == 0 ? pd : c == 1 ? 2'(~pd) : c == 2 ? 2'h3 : {2{pd[0]}}));
      end
    end
    // bilevel X wraps at 19H into Y, Y wraps after 44H
    wr(4'hA, 4'h3);
    wr(4'h0, 4'h8); // addresses rewritten low nibble first
    wr(4'h1, 4'h1);
    wr(4'h2, 4'h4);
    wr(4'h3, 4'h4);
    check("ram addr", 16'(ram_addr), 16'({5'h18, 7'h44}));
    u_host.put(1'b0, 8'($random(seed)));
    check("ram addr", 16'(ram_addr), 16'({5'h19, 7'h44}));
    u_host.put(1'b0, 8'($random(seed)));
    check("ram addr", 16'(ram_addr), 16'h0000);
    // mirrored X, Y only, stepping on writes alone
    wr(4'h9, 4'h1);
    wr(4'hA, 4'h6);
    wr(4'h0, 4'h2);
    wr(4'h1, 4'h0);
    wr(4'h2, 4'h4);
    wr(4'h3, 4'h4);
    check("mirror", 16'(ram_addr), 16'({5'h17, 7'h44}));
    @(negedge clk) ram_rdata = 8'($random(seed));
    exp_q.push_back(16'(ram_rdata));
    u_host.get(1'b0);
    check("read no step", 16'(ram_addr), 16'({5'h17, 7'h44}));
    u_host.put(1'b0, 8'($random(seed)));
    check("y wrap", 16'(ram_addr), 16'({5'h17, 7'h00}));
    // X only, plain mapping, stepping on reads as well
    wr(4'h9, 4'h0);
    wr(4'hA, 4'h1);
    wr(4'h0, 4'h2);
    wr(4'h1, 4'h0);
    wr(4'h2, 4'h0);
    wr(4'h3, 4'h0);
    exp_q.push_back(16'(ram_rdata));
    u_host.get(1'b0);
    check("x read step", 16'(ram_addr), 16'({5'h03, 7'h00}));
    finish_test();
  end
endmodule // ldc_bank_tb

`default_nettype wire
